/* File: logic/ufis_regs.svh */
// Register offsets, field positions, reset values and levels of the UART FIFO block
// Contract
// - FIFOs and receive interrupt enabled: level-2 interrupt while count reaches trigger
// - Status register shows receive code at trigger, withdrawn below trigger
// - Data-ready bit sets when a character enters receive FIFO, clears only empty
// - Transmit interrupt on FIFO emptied by shifter, cleared by status read or write
// - Low four enable bits clear: no interrupts, host polls line status
// - Line status bits one to four report receive errors and break
// - Bit five: transmit FIFO empty; bit six: FIFO and shifter both empty
// - Bit seven set while any receive FIFO character carries an error
// - Mode 0 or FIFOs off: transmit-ready low while no character held
// - Mode 0 or FIFOs off: receive-ready low while a character is held
// - Mode 1: transmit-ready high when full, low once trigger reached; the code drives it low only when the count falls below the trigger
// - Mode 1: receive-ready low at trigger or time-out, held above trigger
// - Mode 1: transmit interrupt below trigger, receive interrupt at trigger
// - Control bits 7-6 pick receive trigger; FIFO keeps loading until full
// - Control bits 5-4 pick transmit trigger, default 16, interrupt below it
// - Control bit 3 selects DMA mode, zero (mode 0) after reset
// - Receive trigger codes: 00=8, 01=16, 10=24, 11=28
// - Transmit trigger codes: 00=16, 01=8, 10=24, 11=30
// - Other control fields ignored unless enable bit set in same write
`ifndef UFIS_REGS_SVH
`define UFIS_REGS_SVH
`define UFIS_DEPTH      32
`define UFIS_OFF_DATA   8'h00
`define UFIS_OFF_INT_EN   8'h04
`define UFIS_OFF_FIFO_CTL 8'h08
`define UFIS_OFF_INT_ST   8'h0C
`define UFIS_OFF_LINE_ST  8'h10
`define UFIS_OFF_STAT     8'h14
`define UFIS_ENA_RX       0
`define UFIS_ENA_TX       1
`define UFIS_ENA_LS       2
`define UFIS_ST_RXC       0
`define UFIS_ST_TXC       8
`define UFIS_ENA_RST      4'h0
`define UFIS_CTRL_RST     8'h00
`define UFIS_TX_READY_RST 1'h0
`define UFIS_RX_READY_RST 1'h1
`define UFIS_RXT_0      6'h08
`define UFIS_RXT_1      6'h10
`define UFIS_RXT_2      6'h18
`define UFIS_RXT_3      6'h1C
`define UFIS_TXT_0      6'h10
`define UFIS_TXT_1      6'h08
`define UFIS_TXT_2      6'h18
`define UFIS_TXT_3      6'h1E
`define UFIS_CODE_LS      4'h6
`define UFIS_CODE_RXTO    4'hC
`define UFIS_CODE_RX      4'h4
`define UFIS_CODE_TX      4'h2
`define UFIS_CODE_NONE    4'h1
`endif

/* File: logic/ufis_pkg.sv */
// Types shared by the UART FIFO signalling block
`default_nettype none
package ufis_pkg;
  typedef struct packed {
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic       dma_mode;
    logic       tx_clr;
    logic       rx_clr;
    logic       en;
  } ufis_ctrl_t;
  typedef struct packed {
    logic tx_rdy_n;
    logic rx_rdy_n;
  } ufis_dma_t;
endpackage
`default_nettype wire

/* File: logic/ufis_lvl_if.sv */
// Fill levels and mode bits passed from the core to the DMA signalling
`default_nettype none
interface ufis_lvl_if #(parameter int CW = 6);
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_trig;
  logic [CW-1:0] tx_trig;
  logic          fifo_en;
  logic          dma_mode;
  logic          rx_to;
  logic          tx_full;
  modport core (output rx_cnt, tx_cnt, rx_trig, tx_trig, fifo_en, dma_mode,
                output rx_to, tx_full);
  modport dma  (input rx_cnt, tx_cnt, rx_trig, tx_trig, fifo_en, dma_mode,
                input rx_to, tx_full);
endinterface
`default_nettype wire

/* File: logic/ufis_mem.sv */
// FIFO storage with registered, write-through read port
`default_nettype none
module ufis_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read side
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rdata_q;
  logic [W-1:0] rdata_d;

  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Bypass so a char written to the head is visible on the next cycle
  always_comb
  begin
    rdata_d = mem[raddr];
    if (we && (waddr == raddr))
    begin
      rdata_d = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

/* File: logic/ufis_dma.sv */
// Transmit-ready and receive-ready pin logic for both DMA modes
`include "ufis_regs.svh"
`default_nettype none
module ufis_dma (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Levels from core
  ufis_lvl_if.dma   lvl,
  // Pins
  output logic      tx_ready_n,
  output logic      rx_ready_n
);
  import ufis_pkg::*;
  ufis_dma_t st_q;
  ufis_dma_t st_d;
  logic      mode1;

  assign mode1 = lvl.fifo_en && lvl.dma_mode;

  always_comb
  begin
    st_d = st_q;
    if (!mode1)
    begin
      st_d.tx_rdy_n = (lvl.tx_cnt != '0);
      st_d.rx_rdy_n = (lvl.rx_cnt == '0);
    end
    else
    begin
      // Hysteresis: stays high from full until below trigger
      if (lvl.tx_full)
      begin
        st_d.tx_rdy_n = 1'b1;
      end
      else if (lvl.tx_cnt < lvl.tx_trig)
      begin
        st_d.tx_rdy_n = 1'b0;
      end
      st_d.rx_rdy_n = !((lvl.rx_cnt >= lvl.rx_trig) || lvl.rx_to);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q.tx_rdy_n <= `UFIS_TX_READY_RST;
      st_q.rx_rdy_n <= `UFIS_RX_READY_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tx_ready_n = st_q.tx_rdy_n;
  assign rx_ready_n = st_q.rx_rdy_n;

  tx_empty_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!mode1 && lvl.tx_cnt == '0) |=> !tx_ready_n)
    else $error("transmit-ready not low with nothing held");
  rx_held_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!mode1 && lvl.rx_cnt != '0) |=> !rx_ready_n)
    else $error("receive-ready not low with data held");
  tx_full_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode1 && lvl.tx_full) |=> tx_ready_n ##1 (tx_ready_n || !lvl.tx_full
      || !mode1))
    else $error("transmit-ready not high when full");
  rx_trig_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode1 && (lvl.rx_cnt >= lvl.rx_trig)) |=> !rx_ready_n)
    else $error("receive-ready not low at trigger");
  rx_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode1 && lvl.rx_cnt < lvl.rx_trig && !lvl.rx_to) |=> rx_ready_n)
    else $error("receive-ready not released below trigger");
endmodule
`default_nettype wire

/* File: logic/ufis_core.sv */
// UART channel FIFO core: APB registers, FIFO counts, interrupts, line status
`include "ufis_regs.svh"
`default_nettype none
module ufis_core #(
  parameter int DEPTH = `UFIS_DEPTH,
  parameter int AW    = $clog2(DEPTH),
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive engine side
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic [2:0]  rx_char_err,
  input  wire logic        rx_timeout,
  // Transmit engine side
  output logic             tx_char_valid,
  output logic      [7:0]  tx_char_data,
  input  wire logic        tx_char_take,
  input  wire logic        tx_shift_empty,
  // Host signalling
  output logic             int_req,
  output logic             tx_ready_n,
  output logic             rx_ready_n
);
  import ufis_pkg::*;

  typedef struct packed {
    logic [AW-1:0] rx_rp;
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] tx_rp;
    logic [AW-1:0] tx_wp;
    logic [CW-1:0] rx_cnt;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] err_cnt;
    logic          fifo_en;
    logic          dma_mode;
    logic [1:0]    rx_sel;
    logic [1:0]    tx_sel;
    logic [3:0]    int_en;
    logic          tx_int;
    logic          rx_to;
    logic          ovr;
    logic [31:0]   prdata;
  } ufis_core_t;

  ufis_core_t    q;
  ufis_core_t    d;
  localparam ufis_ctrl_t ctrl_rst = ufis_ctrl_t'(`UFIS_CTRL_RST);

  ufis_ctrl_t    fw;
  logic [10:0]   rx_head;
  logic [7:0]    tx_head;
  logic [CW-1:0] cap;
  logic [CW-1:0] rx_trig;
  logic [CW-1:0] tx_trig;
  logic          acc;
  logic          wr;
  logic          rd;
  logic          rx_full;
  logic          tx_full;
  logic          rx_push;
  logic          rx_pop;
  logic          tx_push;
  logic          tx_pop;
  logic          tx_evt;
  logic          rx_int;
  logic          ls_err;
  logic [7:0]    line_st;
  logic [3:0]    int_code;
  logic [31:0]   rmux;
  logic [31:0]   stat;

  //////////////////////////////////////////////////////////////////////////
  // Trigger decoding

  function automatic logic [CW-1:0] rx_level(input logic [1:0] s);
    case (s)
      2'h0:    rx_level = CW'(`UFIS_RXT_0);
      2'h1:    rx_level = CW'(`UFIS_RXT_1);
      2'h2:    rx_level = CW'(`UFIS_RXT_2);
      default: rx_level = CW'(`UFIS_RXT_3);
    endcase
  endfunction

  function automatic logic [CW-1:0] tx_level(input logic [1:0] s);
    case (s)
      2'h0:    tx_level = CW'(`UFIS_TXT_0);
      2'h1:    tx_level = CW'(`UFIS_TXT_1);
      2'h2:    tx_level = CW'(`UFIS_TXT_2);
      default: tx_level = CW'(`UFIS_TXT_3);
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `UFIS_OFF_DATA) || (a == `UFIS_OFF_INT_EN)
          || (a == `UFIS_OFF_FIFO_CTL) || (a == `UFIS_OFF_INT_ST)
          || (a == `UFIS_OFF_LINE_ST) || (a == `UFIS_OFF_STAT);
  endfunction

  assign rx_trig = rx_level(q.rx_sel);
  assign tx_trig = tx_level(q.tx_sel);

  //////////////////////////////////////////////////////////////////////////
  // Bus and FIFO movement

  // Zero wait states: read data is captured in the setup cycle
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && mapped(paddr);
  assign rd      = acc && !pwrite && mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped(paddr);
  assign prdata  = q.prdata;
  assign fw      = ufis_ctrl_t'(pwdata[7:0]);

  // Without FIFOs each direction holds a single character
  assign cap     = q.fifo_en ? CW'(DEPTH) : CW'(1);
  assign rx_full = (q.rx_cnt >= cap);
  assign tx_full = (q.tx_cnt >= cap);
  // Receive keeps loading past the trigger until full
  assign rx_push = rx_char_valid && !rx_full;
  assign rx_pop  = rd && (paddr == `UFIS_OFF_DATA) && (q.rx_cnt != '0);
  assign tx_push = wr && (paddr == `UFIS_OFF_DATA) && !tx_full;
  assign tx_pop  = tx_char_take && (q.tx_cnt != '0);

  // Emptied by shifter in mode 0, dropped below trigger in mode 1
  always_comb
  begin
    if (q.fifo_en && q.dma_mode)
    begin
      tx_evt = tx_pop && !tx_push && (q.tx_cnt == tx_trig);
    end
    else
    begin
      tx_evt = tx_pop && !tx_push && (q.tx_cnt == CW'(1));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status and interrupts

  assign ls_err = q.ovr || ((q.rx_cnt != '0) && (rx_head[10:8] != 3'h0));
  assign line_st[0] = (q.rx_cnt != '0);
  assign line_st[1] = q.ovr;
  assign line_st[4:2] = (q.rx_cnt != '0) ? rx_head[10:8] : 3'h0;
  assign line_st[5] = (q.tx_cnt == '0);
  assign line_st[6] = (q.tx_cnt == '0) && tx_shift_empty;
  assign line_st[7] = (q.err_cnt != '0);

  always_comb
  begin
    if (q.fifo_en)
    begin
      rx_int = q.int_en[`UFIS_ENA_RX]
            && (q.rx_cnt >= rx_trig);
    end
    else
    begin
      rx_int = q.int_en[`UFIS_ENA_RX] && (q.rx_cnt != '0);
    end
  end

  // Every source is gated by its enable bit; the time-out shares the receive enable
  always_comb
  begin
    if (q.int_en[`UFIS_ENA_LS] && ls_err)
    begin
      int_code = `UFIS_CODE_LS;
    end
    else if (q.int_en[`UFIS_ENA_RX] && q.rx_to)
    begin
      int_code = `UFIS_CODE_RXTO;
    end
    else if (rx_int)
    begin
      int_code = `UFIS_CODE_RX;
    end
    else if (q.int_en[`UFIS_ENA_TX] && q.tx_int)
    begin
      int_code = `UFIS_CODE_TX;
    end
    else
    begin
      int_code = `UFIS_CODE_NONE;
    end
  end

  assign int_req = (int_code != `UFIS_CODE_NONE);

  always_comb
  begin
    stat = '0;
    stat[`UFIS_ST_RXC +: CW] = q.rx_cnt;
    stat[`UFIS_ST_TXC +: CW] = q.tx_cnt;
    case (paddr)
      `UFIS_OFF_DATA: rmux = {24'h000000, rx_head[7:0]};
      `UFIS_OFF_INT_EN:  rmux = {28'h0000000, q.int_en};
      `UFIS_OFF_INT_ST:
        rmux = {24'h000000, q.fifo_en, q.fifo_en, 2'h0, int_code};
      `UFIS_OFF_LINE_ST: rmux = {24'h000000, line_st};
      `UFIS_OFF_STAT: rmux = stat;
      default:        rmux = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic rx_clr;
    logic tx_clr;
    rx_clr = 1'b0;
    tx_clr = 1'b0;
    d = q;
    if (psel && !penable)
    begin
      d.prdata = pwrite ? 32'h00000000 : rmux;
    end
    if (wr && (paddr == `UFIS_OFF_INT_EN))
    begin
      d.int_en = pwdata[3:0];
    end
    if (wr && (paddr == `UFIS_OFF_FIFO_CTL))
    begin
      d.fifo_en = fw.en;
      if (fw.en)
      begin
        d.rx_sel   = fw.rx_sel;
        d.tx_sel   = fw.tx_sel;
        d.dma_mode = fw.dma_mode;
        rx_clr     = fw.rx_clr;
        tx_clr     = fw.tx_clr;
      end
      // Changing FIFO mode flushes both directions
      if (fw.en != q.fifo_en)
      begin
        rx_clr = 1'b1;
        tx_clr = 1'b1;
      end
    end
    d.rx_rp   = q.rx_rp + AW'(rx_pop);
    d.rx_wp   = q.rx_wp + AW'(rx_push);
    d.rx_cnt  = q.rx_cnt + CW'(rx_push) - CW'(rx_pop);
    d.err_cnt = q.err_cnt + CW'(rx_push && (rx_char_err != 3'h0))
              - CW'(rx_pop && (rx_head[10:8] != 3'h0));
    d.tx_rp   = q.tx_rp + AW'(tx_pop);
    d.tx_wp   = q.tx_wp + AW'(tx_push);
    d.tx_cnt  = q.tx_cnt + CW'(tx_push) - CW'(tx_pop);
    // Set wins over the clearing read; a write in the same cycle blocks the set
    d.tx_int = tx_evt || (q.tx_int && !tx_push
             && !(rd && (paddr == `UFIS_OFF_INT_ST)));
    d.rx_to  = (rx_timeout && (q.rx_cnt != '0)) || (q.rx_to && !rx_pop);
    d.ovr    = (rx_char_valid && rx_full)
             || (q.ovr && !(rd && (paddr == `UFIS_OFF_LINE_ST)));
    if (rx_clr)
    begin
      d.rx_rp   = '0;
      d.rx_wp   = '0;
      d.rx_cnt  = '0;
      d.err_cnt = '0;
      d.rx_to   = 1'b0;
    end
    if (tx_clr)
    begin
      d.tx_rp  = '0;
      d.tx_wp  = '0;
      d.tx_cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q          <= '0;
      q.fifo_en  <= ctrl_rst.en;
      q.dma_mode <= ctrl_rst.dma_mode;
      q.rx_sel   <= ctrl_rst.rx_sel;
      q.tx_sel   <= ctrl_rst.tx_sel;
      q.int_en   <= `UFIS_ENA_RST;
    end
    else
    begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage and DMA pins

  ufis_mem #(.W(11), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (rx_push),
    .waddr   (q.rx_wp),
    .wdata   ({rx_char_err, rx_char_data}),
    .raddr   (d.rx_rp),
    .rdata   (rx_head)
  );

  ufis_mem #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_tx_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (tx_push),
    .waddr   (q.tx_wp),
    .wdata   (pwdata[7:0]),
    .raddr   (d.tx_rp),
    .rdata   (tx_head)
  );

  assign tx_char_valid = (q.tx_cnt != '0);
  assign tx_char_data  = tx_head;

  ufis_lvl_if #(.CW(CW)) lvl ();
  assign lvl.rx_cnt   = q.rx_cnt;
  assign lvl.tx_cnt   = q.tx_cnt;
  assign lvl.rx_trig  = rx_trig;
  assign lvl.tx_trig  = tx_trig;
  assign lvl.fifo_en  = q.fifo_en;
  assign lvl.dma_mode = q.dma_mode;
  assign lvl.rx_to    = q.rx_to;
  assign lvl.tx_full  = tx_full;

  ufis_dma u_dma (
    .pclk       (pclk),
    .presetn    (presetn),
    .lvl        (lvl),
    .tx_ready_n (tx_ready_n),
    .rx_ready_n (rx_ready_n)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks

  rx_int_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fifo_en && q.int_en[0] && q.rx_cnt >= rx_trig) |-> int_req)
    else $error("receive interrupt missing at trigger");
  status_rx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fifo_en && q.rx_cnt < rx_trig) |-> (int_code != `UFIS_CODE_RX))
    else $error("receive code shown below trigger");
  data_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_push && !(wr && paddr == `UFIS_OFF_FIFO_CTL)) |=> line_st[0])
    else $error("data-ready not set after receive push");
  tx_int_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_evt && q.int_en[1] && !(wr && paddr == `UFIS_OFF_FIFO_CTL))
      |=> q.tx_int)
    else $error("transmit interrupt not raised");
  poll_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.int_en == 4'h0) |-> !int_req)
    else $error("interrupt raised with all enables clear");
  shift_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    line_st[6] |-> (line_st[5] && tx_shift_empty))
    else $error("all-empty bit without empty FIFO");
  err_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_push && rx_char_err != 3'h0 && !(wr && paddr == `UFIS_OFF_FIFO_CTL))
      |=> line_st[7])
    else $error("error flag not set for bad character");
  ctrl_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `UFIS_OFF_FIFO_CTL && !pwdata[0])
      |=> ($stable(q.dma_mode) && $stable(q.rx_sel) && $stable(q.tx_sel)))
    else $error("control fields taken without enable bit");
endmodule
`default_nettype wire

/* File: verification/ufis_eng_model.sv */
// Model of the receive and transmit serial engines around the core
`default_nettype none
module ufis_eng_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Receive engine
  output var  logic       rx_char_valid,
  output var  logic [7:0] rx_char_data,
  output var  logic [2:0] rx_char_err,
  output var  logic       rx_timeout,
  // Transmit engine
  input  wire logic       tx_char_valid,
  input  wire logic [7:0] tx_char_data,
  output var  logic       tx_char_take,
  output logic            tx_shift_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  logic [2:0] busy_q;
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    rx_char_err = 3'h0;
    rx_timeout = 1'b0;
    tx_char_take = 1'b0;
  end
  // Shifter stays busy a few cycles per character
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      busy_q <= 3'h0;
    else if (tx_char_take)
      busy_q <= 3'h4;
    else if (busy_q != 3'h0)
      busy_q <= busy_q - 3'h1;
  assign tx_shift_empty = (busy_q == 3'h0);
  task automatic send_rx(input logic [7:0] d, input logic [2:0] e);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_char_err <= e;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    // Idle data is not left showing the last character
    rx_char_data <= ~d;
    rx_char_err <= ~e;
  endtask
  task automatic pulse_to();
    @(posedge pclk);
    rx_timeout <= 1'b1;
    @(posedge pclk);
    rx_timeout <= 1'b0;
  endtask
  task automatic drain(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      while (tx_char_valid !== 1'b1)
        @(posedge pclk);
      tx_char_take <= 1'b1;
      last_q <= tx_char_data;
      @(posedge pclk);
      tx_char_take <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/test_uart_fifo_irq_dma_signalling.sv */
// Self-checking bench of the UART FIFO signalling core
`include "ufis_regs.svh"
`default_nettype none
module test_uart_fifo_irq_dma_signalling;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, err_q, int_req, tx_ready_n, rx_ready_n;
  logic        tx_char_valid, tx_char_take, tx_shift_empty;
  logic        rx_char_valid, rx_timeout;
  logic [7:0]  tx_char_data, rx_char_data;
  logic [2:0]  rx_char_err;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  always #2.5 pclk = ~pclk;
  ufis_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_char_valid, .rx_char_data,
    .rx_char_err, .rx_timeout, .tx_char_valid, .tx_char_data,
    .tx_char_take, .tx_shift_empty, .int_req, .tx_ready_n, .rx_ready_n);
  ufis_eng_model pm_u (.pclk, .presetn, .rx_char_valid, .rx_char_data,
    .rx_char_err, .rx_timeout, .tx_char_valid, .tx_char_data,
    .tx_char_take, .tx_shift_empty);
  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    apb(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    apb(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++)
      pm_u.send_rx(8'(i), 3'h0);
    w(3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(tx_ready_n, 1'b0);
    chk(rx_ready_n, 1'b1);
    rdc(`UFIS_OFF_LINE_ST, 32'h60);
    rdc(`UFIS_OFF_INT_ST, 32'h01);
  endtask
  task automatic t_rx_levels();
    logic [5:0] trig [4];
    trig = '{`UFIS_RXT_0, `UFIS_RXT_1, `UFIS_RXT_2, `UFIS_RXT_3};
    wr(`UFIS_OFF_INT_EN, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      wr(`UFIS_OFF_FIFO_CTL, 32'h03 | (k << 6));
      push(trig[k] - 1);
      chk(int_req, 1'b0);
      push(1);
      chk(int_req, 1'b1);
      rdc(`UFIS_OFF_INT_ST, 32'hC4);
      chk(rx_ready_n, 1'b0);
    end
    rdc(`UFIS_OFF_DATA, 32'h0);
    w(2);
    chk(int_req, 1'b0);
    rdc(`UFIS_OFF_INT_ST, 32'hC1);
    wr(`UFIS_OFF_INT_EN, 32'h0);
    push(1);
    chk(int_req, 1'b0);
    rdc(`UFIS_OFF_LINE_ST, 32'h61);
    push(5);
    rdc(`UFIS_OFF_STAT, 32'h20);
    // Fifth extra character overran the full FIFO; this read clears it
    rdc(`UFIS_OFF_LINE_ST, 32'h63);
  endtask
  task automatic t_rx_mode1();
    wr(`UFIS_OFF_FIFO_CTL, 32'h4B);
    push(15);
    chk(rx_ready_n, 1'b1);
    push(1);
    chk(rx_ready_n, 1'b0);
    rdc(`UFIS_OFF_DATA, 32'h0);
    w(3);
    chk(rx_ready_n, 1'b1);
    // Time-out below the trigger also requests the DMA
    pm_u.pulse_to();
    w(3);
    chk(rx_ready_n, 1'b0);
    rdc(`UFIS_OFF_DATA, 32'h1);
    w(3);
    chk(rx_ready_n, 1'b1);
  endtask
  task automatic t_rx_error();
    wr(`UFIS_OFF_FIFO_CTL, 32'h03);
    pm_u.send_rx(8'hA5, 3'h1);
    w(3);
    rdc(`UFIS_OFF_LINE_ST, 32'hE5);
    rdc(`UFIS_OFF_DATA, 32'hA5);
    rdc(`UFIS_OFF_LINE_ST, 32'h60);
  endtask
  task automatic t_tx_mode0();
    wr(`UFIS_OFF_FIFO_CTL, 32'h05);
    wr(`UFIS_OFF_INT_EN, 32'h2);
    wr(`UFIS_OFF_DATA, 32'h5A);
    w(2);
    chk(tx_ready_n, 1'b1);
    rdc(`UFIS_OFF_LINE_ST, 32'h00);
    pm_u.drain(1);
    chk(pm_u.last_q, 8'h5A);
    rdc(`UFIS_OFF_LINE_ST, 32'h20);
    chk(int_req, 1'b1);
    chk(tx_ready_n, 1'b0);
    rdc(`UFIS_OFF_INT_ST, 32'hC2);
    w(1);
    chk(int_req, 1'b0);
    w(6);
    rdc(`UFIS_OFF_LINE_ST, 32'h60);
  endtask
  task automatic t_tx_mode1();
    wr(`UFIS_OFF_FIFO_CTL, 32'h3D);
    for (int i = 0; i < 32; i++)
      wr(`UFIS_OFF_DATA, i);
    w(3);
    chk(tx_ready_n, 1'b1);
    chk(int_req, 1'b0);
    pm_u.drain(2);
    w(3);
    chk(tx_ready_n, 1'b1);
    pm_u.drain(1);
    w(3);
    chk(tx_ready_n, 1'b0);
    chk(int_req, 1'b1);
    // A new transmit character withdraws the pending interrupt
    wr(`UFIS_OFF_DATA, 32'hA5);
    w(1);
    chk(int_req, 1'b0);
  endtask
  task automatic t_unmapped();
    logic [31:0] rd;
    apb(1'b0, 8'h20, 32'h0, rd);
    chk(err_q, 1'b1);
  endtask
  initial
  begin
    w(4);
    presetn <= 1'b1;
    t_reset();
    t_rx_levels();
    t_rx_mode1();
    t_rx_error();
    t_tx_mode0();
    t_tx_mode1();
    t_unmapped();
    final_report();
  end
endmodule
`default_nettype wire
